// >>> kli_pkg.sv
// Overview of operation
// - Hardware sets a line's flag while the line shows its chosen level.
// - Reading the flag register clears the flags; no write is needed.
// - After reset the flag and enable registers both read all zeros.
// - With its enable bit clear a line stays an ordinary port pin.
// - Enable bit n gates flag bit n, for positions 0 through 7.
// - Level-select zero detects a low level, one detects a high level.
// - Eight sources share one request, gated by a global keyboard enable.
package kli_pkg;
   localparam int KLI_LINES = 8;
   localparam int KLI_ADDR_W = 8;
   // Indices sit in address bits 9:2, so a byte address is four times an index.
   localparam logic [7:0] KLI_IDX_LEVEL_SELECT = 8'h9C;
   localparam logic [7:0] KLI_IDX_LINE_ENABLE = 8'h9D;
   localparam logic [7:0] KLI_IDX_LINE_FLAGS = 8'h9E;
   localparam logic [7:0] KLI_IDX_GLOBAL_CTRL = 8'h9F;
   localparam logic [7:0] KLI_IDX_IRQ_STATUS = 8'hA0;
   localparam logic [7:0] KLI_IDX_IRQ_ENABLE = 8'hA1;
   localparam logic [7:0] KLI_IDX_IRQ_CLEAR = 8'hA2;
   localparam int KLI_GLOBAL_EN_BIT = 0;
   localparam int KLI_EVT_W = 2;
   localparam int KLI_EVT_KEY_BIT = 0;
   localparam int KLI_EVT_LOST_BIT = 1;
   localparam logic [7:0] KLI_RESET_BYTE = 8'h00;
   localparam logic [1:0] KLI_RESET_EVT = 2'h0;
   localparam logic [31:0] KLI_ZERO_WORD = 32'h0000_0000;
endpackage : kli_pkg

// >>> kli_sync.sv
`timescale 1ns/1ps
`default_nettype none
module kli_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] next_stage_one;
   logic [WIDTH-1:0] next_sync_out;

   always_comb begin
      next_stage_one = async_in;
      next_sync_out = stage_one;
   end

   // Reset loads the pulled-up idle level, so no false low is seen after reset.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stage_one <= '1;
         sync_out <= '1;
      end else begin
         stage_one <= next_stage_one;
         sync_out <= next_sync_out;
      end
   end
endmodule : kli_sync
`default_nettype wire

// >>> kli_keypad.sv
`timescale 1ns/1ps
`default_nettype none
module kli_keypad #(
   parameter int LINES = kli_pkg::KLI_LINES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Port lines
   input wire logic [LINES-1:0] port_in,
   output logic [LINES-1:0] key_line_active,
   // Interrupts
   output logic key_irq,
   output logic irq
);
   // Synchronised pins and per-line terms.
   logic [LINES-1:0] port_sync;
   logic [LINES-1:0] level_hit;
   logic [LINES-1:0] new_hit;
   logic [LINES-1:0] lost_hit;
   logic [LINES-1:0] line_request;

   // Registers and their next values.
   logic [LINES-1:0] key_level_select;
   logic [LINES-1:0] next_key_level_select;
   logic [LINES-1:0] key_line_enable;
   logic [LINES-1:0] next_key_line_enable;
   logic [LINES-1:0] key_line_flags;
   logic [LINES-1:0] next_key_line_flags;
   logic keypad_global_irq_enable;
   logic next_keypad_global_irq_enable;
   logic [kli_pkg::KLI_EVT_W-1:0] irq_status;
   logic [kli_pkg::KLI_EVT_W-1:0] next_irq_status;
   logic [kli_pkg::KLI_EVT_W-1:0] irq_enable;
   logic [kli_pkg::KLI_EVT_W-1:0] next_irq_enable;
   logic [31:0] next_wb_dat_o;
   logic next_wb_ack_o;
   logic [LINES-1:0] next_key_line_active;
   logic next_key_irq;
   logic next_irq;

   // Bus decode.
   logic [7:0] reg_index;
   logic access;
   logic wr;
   logic rd;
   logic flags_read;
   logic [LINES-1:0] wr_byte;

   kli_sync #(
      .WIDTH(LINES)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .async_in(port_in),
      .sync_out(port_sync)
   );

   // Per-line detection, flag and request terms.
   genvar g;
   generate
      for (g = 0; g < LINES; g++) begin : g_line
         // Selector one means active high.
         assign level_hit[g] = port_sync[g] ~^ key_level_select[g];
         // A level held through the clearing read wins, so no press is lost.
         assign next_key_line_flags[g] = level_hit[g] ||
            (key_line_flags[g] && !flags_read);
         assign new_hit[g] = level_hit[g] && !key_line_flags[g];
         assign lost_hit[g] = level_hit[g] && key_line_flags[g] &&
            !key_line_enable[g];
         assign line_request[g] = key_line_flags[g] &&
            key_line_enable[g];
      end
   endgenerate

   // A request is taken once, in the cycle before its ack.
   always_comb begin
      reg_index = wb_adr_i[9:2];
      access = wb_cyc_i && wb_stb_i && !wb_ack_o;
      wr = access && wb_we_i && wb_sel_i[0];
      rd = access && !wb_we_i;
      flags_read = rd && (reg_index == kli_pkg::KLI_IDX_LINE_FLAGS);
      wr_byte = wb_dat_i[LINES-1:0];
   end

   // Read data stands only beside ack, so the bus idles at zero.
   always_comb begin
      next_wb_ack_o = access;
      next_wb_dat_o = kli_pkg::KLI_ZERO_WORD;
      if (rd) begin
         case (reg_index)
            kli_pkg::KLI_IDX_LEVEL_SELECT: begin
               next_wb_dat_o[LINES-1:0] = key_level_select;
            end
            kli_pkg::KLI_IDX_LINE_ENABLE: begin
               next_wb_dat_o[LINES-1:0] = key_line_enable;
            end
            kli_pkg::KLI_IDX_LINE_FLAGS: begin
               next_wb_dat_o[LINES-1:0] = key_line_flags;
            end
            kli_pkg::KLI_IDX_GLOBAL_CTRL: begin
               next_wb_dat_o[kli_pkg::KLI_GLOBAL_EN_BIT] =
                  keypad_global_irq_enable;
            end
            kli_pkg::KLI_IDX_IRQ_STATUS: begin
               next_wb_dat_o[kli_pkg::KLI_EVT_W-1:0] = irq_status;
            end
            kli_pkg::KLI_IDX_IRQ_ENABLE: begin
               next_wb_dat_o[kli_pkg::KLI_EVT_W-1:0] = irq_enable;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_o <= kli_pkg::KLI_ZERO_WORD;
         wb_ack_o <= 1'b0;
      end else begin
         wb_dat_o <= next_wb_dat_o;
         wb_ack_o <= next_wb_ack_o;
      end
   end

   // Software-written control; writes with byte lane 0 off are dropped.
   always_comb begin
      next_key_level_select = key_level_select;
      next_key_line_enable = key_line_enable;
      next_keypad_global_irq_enable = keypad_global_irq_enable;
      next_irq_enable = irq_enable;
      if (wr) begin
         case (reg_index)
            kli_pkg::KLI_IDX_LEVEL_SELECT: begin
               next_key_level_select = wr_byte;
            end
            kli_pkg::KLI_IDX_LINE_ENABLE: begin
               next_key_line_enable = wr_byte;
            end
            kli_pkg::KLI_IDX_GLOBAL_CTRL: begin
               next_keypad_global_irq_enable =
                  wb_dat_i[kli_pkg::KLI_GLOBAL_EN_BIT];
            end
            kli_pkg::KLI_IDX_IRQ_ENABLE: begin
               next_irq_enable = wb_dat_i[kli_pkg::KLI_EVT_W-1:0];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         key_level_select <= kli_pkg::KLI_RESET_BYTE[LINES-1:0];
         key_line_enable <= kli_pkg::KLI_RESET_BYTE[LINES-1:0];
         keypad_global_irq_enable <= 1'b0;
         irq_enable <= kli_pkg::KLI_RESET_EVT;
      end else begin
         key_level_select <= next_key_level_select;
         key_line_enable <= next_key_line_enable;
         keypad_global_irq_enable <= next_keypad_global_irq_enable;
         irq_enable <= next_irq_enable;
      end
   end

   // Clear first, then set, so an event in the clearing cycle is kept.
   always_comb begin
      next_irq_status = irq_status;
      if (wr && (reg_index == kli_pkg::KLI_IDX_IRQ_CLEAR)) begin
         next_irq_status = irq_status &
            ~wb_dat_i[kli_pkg::KLI_EVT_W-1:0];
      end
      if (|new_hit) begin
         next_irq_status[kli_pkg::KLI_EVT_KEY_BIT] = 1'b1;
      end
      // A hit on a set, disabled line is kept for software as a lost event.
      if (|lost_hit) begin
         next_irq_status[kli_pkg::KLI_EVT_LOST_BIT] = 1'b1;
      end
   end

   // Flags and event bits share a group because one hit moves both.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         key_line_flags <= kli_pkg::KLI_RESET_BYTE[LINES-1:0];
         irq_status <= kli_pkg::KLI_RESET_EVT;
      end else begin
         key_line_flags <= next_key_line_flags;
         irq_status <= next_irq_status;
      end
   end

   // Lines with a clear enable never reach key_irq; irq still sees their hits through irq_status.
   always_comb begin
      next_key_line_active = key_line_enable;
      next_key_irq = keypad_global_irq_enable &&
         |line_request;
      next_irq = |(irq_status & irq_enable);
   end

   // Every output leaves a flip-flop, so the requests never glitch.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         key_line_active <= '0;
         key_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         key_line_active <= next_key_line_active;
         key_irq <= next_key_irq;
         irq <= next_irq;
      end
   end
endmodule : kli_keypad
`default_nettype wire

// >>> kli_keypad_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module kli_keypad_monitor #(
   parameter int LINES = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Lines and requests
   input wire logic [LINES-1:0] key_line_active,
   input wire logic key_irq
);
   logic [LINES-1:0] en_q;
   logic en_wr;
   assign en_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i[9:2] == kli_pkg::KLI_IDX_LINE_ENABLE;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) en_q <= '0;
      else if (en_wr) en_q <= wb_dat_i[LINES-1:0];
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_ACK_NEXT: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_UPPER_ZERO: assert property (
      wb_ack_o |-> wb_dat_o[31:LINES] == '0)
      else $error("upper read bits set");
   AST_RESET_QUIET: assert property (
      $rose(rst_b) |-> !key_irq && !wb_ack_o && key_line_active == '0)
      else $error("outputs busy after reset");
   AST_MASKED_QUIET: assert property (
      key_line_active == '0 [*2] |-> !key_irq)
      else $error("request with no line enabled");
   AST_EN_WRITE: assert property (
      en_wr |-> ##[1:2] key_line_active == en_q)
      else $error("line enable not applied");
   AST_IRQ_NEEDS_EN: assert property (key_irq |-> key_line_active != '0
      || $past(key_line_active) != '0) else $error("request while disabled");
endmodule : kli_keypad_monitor
bind kli_keypad kli_keypad_monitor #(.LINES(LINES)) u_mon (.clk_sys, .rst_b,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .key_line_active, .key_irq);
`default_nettype wire

// >>> kli_key_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module kli_key_matrix (
   // Key state and wiring
   input wire logic [7:0] press,
   input wire logic [7:0] to_high,
   // Port lines
   output logic [7:0] port_in
);
   // A released key leaves its line at the far rail through its resistor.
   assign port_in = ~(press ^ to_high);
endmodule : kli_key_matrix
`default_nettype wire

// >>> kli_keypad_tb.sv
`timescale 1ns/1ps
`default_nettype none
module kli_keypad_tb;
   logic clk_sys, rst_b, cyc, stb, we, key_irq, irq, ack;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_o, dat_r;
   logic [7:0] press, wiring, port_in, active;
   int n_mismatch, total_checks, cycles;
   kli_key_matrix keys (.press, .to_high(wiring), .port_in);
   kli_keypad dut (.clk_sys, .rst_b, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .port_in, .key_line_active(active),
      .key_irq, .irq);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic check(input string n, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
      input logic [3:0] s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= s;
      do @(posedge clk_sys); while (ack !== 1'b1);
      dat_r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_sys);
   endtask : wb
   task automatic settle;
      repeat (5) @(posedge clk_sys);
   endtask : settle
   task automatic t_levels;
      wiring <= 8'h0F;
      wb(1'b1, 10'h270, 32'h0F, 4'hF);
      settle;
      wb(1'b0, 10'h270, 32'h0, 4'hF);
      check("level select", dat_r, 32'h0F);
      wb(1'b0, 10'h278, 32'h0, 4'hF);
      wb(1'b0, 10'h278, 32'h0, 4'hF);
      check("flags idle", dat_r, 32'h0);
      press <= 8'h81;
      settle;
      wb(1'b0, 10'h278, 32'h0, 4'hF);
      check("flags held", dat_r, 32'h81);
      check("masked request", {31'h0, key_irq}, 32'h0);
      press <= 8'h00;
      settle;
      wb(1'b0, 10'h278, 32'h0, 4'hF);
      check("flags sticky", dat_r, 32'h81);
      wb(1'b0, 10'h278, 32'h0, 4'hF);
      check("flags cleared", dat_r, 32'h0);
   endtask : t_levels
   task automatic t_gate;
      wb(1'b1, 10'h27C, 32'h1, 4'hF);
      wb(1'b0, 10'h27C, 32'h0, 4'hF);
      check("global on", dat_r, 32'h1);
      wb(1'b1, 10'h274, 32'h1, 4'hF);
      press <= 8'h80;
      settle;
      check("other line request", {31'h0, key_irq}, 32'h0);
      check("active lines", {24'h0, active}, 32'h1);
      press <= 8'h81;
      settle;
      check("request", {31'h0, key_irq}, 32'h1);
      wb(1'b1, 10'h27C, 32'h0, 4'hF);
      settle;
      check("global off", {31'h0, key_irq}, 32'h0);
      wb(1'b1, 10'h274, 32'h0, 4'hE);
      wb(1'b0, 10'h274, 32'h0, 4'hF);
      check("enable kept", dat_r, 32'h1);
      press <= 8'h00;
      wb(1'b0, 10'h3FC, 32'h0, 4'hF);
      check("unmapped", dat_r, 32'h0);
   endtask : t_gate
   task automatic t_irq;
      wb(1'b0, 10'h280, 32'h0, 4'hF);
      check("status events", dat_r, 32'h3);
      wb(1'b1, 10'h284, 32'h1, 4'hF);
      settle;
      check("irq raised", {31'h0, irq}, 32'h1);
      wb(1'b1, 10'h284, 32'h0, 4'hF);
      settle;
      check("irq masked", {31'h0, irq}, 32'h0);
      wb(1'b1, 10'h288, 32'h3, 4'hF);
      wb(1'b1, 10'h284, 32'h1, 4'hF);
      settle;
      check("irq cleared", {31'h0, irq}, 32'h0);
      wb(1'b0, 10'h280, 32'h0, 4'hF);
      check("status cleared", dat_r, 32'h0);
   endtask : t_irq
   task automatic stop_test;
      if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         stop_test;
      end
   end
   initial begin
      {cyc, stb, we, adr, sel, dat_w, press, wiring} = '0;
      rst_b = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      wb(1'b0, 10'h274, 32'h0, 4'hF);
      check("enable reset", dat_r, 32'h0);
      wb(1'b0, 10'h278, 32'h0, 4'hF);
      check("flags reset", dat_r, 32'h0);
      t_levels;
      t_gate;
      t_irq;
      stop_test;
   end
endmodule : kli_keypad_tb
`default_nettype wire
